// file: logic/cbbc_pkg.sv
// Purpose: Constants for the bridging control register bank.
// Assumes: 16-bit register at one configuration offset, one copy per socket function.
// Notes:   Field positions and reset values are those of the register layout.
package cbbc_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int          REG_W                 = 16;
  localparam int          ADDR_W                = 8;
  localparam logic [7:0]  BRIDGING_CONTROL_OFS  = 8'h3E;
  localparam logic [15:0] BRIDGING_CONTROL_RST  = 16'h0340;
  localparam logic [15:0] BRIDGING_CONTROL_MASK = 16'h07EF;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int POS_WRITE_POSTING    = 10;
  localparam int POS_WINDOW1_PREFETCH = 9;
  localparam int POS_WINDOW0_PREFETCH = 8;
  localparam int POS_IRQ_ROUTING      = 7;
  localparam int POS_CARD_RESET       = 6;
  localparam int POS_MASTER_ABORT     = 5;
  localparam int POS_VGA_FORWARD      = 3;
  localparam int POS_ISA_FILTER       = 2;
  localparam int POS_CARD_SYSERR      = 1;
  localparam int POS_CARD_PARITY      = 0;

  // ==========================================================================
  // ISA range decode
  // ==========================================================================
  localparam int          IO_ADDR_W       = 32;
  localparam int          ISA_TOP_BIT     = 16;
  localparam int          ISA_BLOCK_LO    = 8;
  localparam int          ISA_BLOCK_HI    = 9;
  localparam logic [15:0] ISA_UPPER_ZERO  = 16'h0000;
  localparam logic [1:0]  ISA_FIRST_QUART = 2'h0;

  // ==========================================================================
  // Byte lanes
  // ==========================================================================
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
endpackage

// file: logic/cbbc_bridging_control.sv
// Purpose: Bridging control register bank of a dual-socket card bridge, with
//          the socket control outputs and error forwarding it steers.
// Assumes: Configuration accesses arrive as one-cycle strobes synchronous to clock_in;
//          rst_in is the global reset, pci_reset_input_in a synchronous level.
// Notes:   Function number selects the socket copy; shared fields have one copy.
//
// Behaviour
// - Bits 15 to 11 read zero, ignore writes.
// - Per-socket write posting enable steers posting.
// - Per-socket window one prefetchable, resets to one.
// - Per-socket window zero prefetchable, resets to one.
// - Interrupt routing: zero PCI, one legacy registers.
// - Card reset field drives card reset output.
// - PCI reset input also asserts card reset.
// - Card reset field reset to one by global reset only, never by PCI reset.
// - Context fields: PCI reset restores reset values unless events enabled.
// - Shared master abort mode reports target abort, SERR.
// - Bit 4 reads zero, ignores writes.
// - VGA forward enable forwards VGA range accesses.
// - ISA filter blocks last 768 bytes per 1K of the first 64K.
// - Card system errors forwarded to SERR when enabled.
// - Card parity errors reported when response enabled.
`timescale 1ns/1ps
module cbbc_bridging_control #(
  parameter int NUM_SOCKETS = 2
) (
  // Clock and resets
  input  wire logic                              clock_in,
  input  wire logic                              rst_in,
  input  wire logic                              pci_reset_input_in,
  input  wire logic                              pme_enable_in,
  // Configuration access
  input  wire logic                              cfg_wr_in,
  input  wire logic                              cfg_rd_in,
  input  wire logic                              cfg_func_in,
  input  wire logic [cbbc_pkg::ADDR_W-1:0]       cfg_addr_in,
  input  wire logic [1:0]                        cfg_byte_en_in,
  input  wire logic [cbbc_pkg::REG_W-1:0]        cfg_wdata_in,
  output logic      [cbbc_pkg::REG_W-1:0]        cfg_rdata_out,
  output logic                                   cfg_rd_valid_out,
  // Socket control levels
  output logic      [NUM_SOCKETS-1:0]            write_posting_enable_out,
  output logic      [NUM_SOCKETS-1:0]            window1_prefetchable_out,
  output logic      [NUM_SOCKETS-1:0]            window0_prefetchable_out,
  output logic      [NUM_SOCKETS-1:0]            irq_routing_select_out,
  output logic      [NUM_SOCKETS-1:0]            vga_forward_enable_out,
  output logic      [NUM_SOCKETS-1:0]            card_reset_out,
  output logic                                   master_abort_report_mode_out,
  // Card functional interrupts
  input  wire logic [NUM_SOCKETS-1:0]            card_irq_in,
  output logic      [NUM_SOCKETS-1:0]            card_irq_to_pci_out,
  output logic      [NUM_SOCKETS-1:0]            card_irq_to_legacy_out,
  // I/O cycle forwarding decision
  input  wire logic                              io_cycle_valid_in,
  input  wire logic                              io_cycle_socket_in,
  input  wire logic [cbbc_pkg::IO_ADDR_W-1:0]    io_cycle_addr_in,
  output logic                                   io_cycle_blocked_out,
  output logic                                   io_cycle_decided_out,
  // Error events
  input  wire logic [NUM_SOCKETS-1:0]            card_master_abort_in,
  input  wire logic [NUM_SOCKETS-1:0]            card_syserr_in,
  input  wire logic [NUM_SOCKETS-1:0]            card_parity_err_in,
  input  wire logic                              serr_enable_in,
  output logic                                   pci_target_abort_out,
  output logic                                   pci_serr_out,
  output logic      [NUM_SOCKETS-1:0]            card_parity_err_out
);
  import cbbc_pkg::*;

  // Only one or two sockets fit the single function-number bit.
  if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2) begin : g_bad_sockets
    $error("NUM_SOCKETS must be 1 or 2");
  end

  // ==========================================================================
  // Access decode
  // ==========================================================================
  logic [NUM_SOCKETS-1:0] posting_q;
  logic [NUM_SOCKETS-1:0] win1_q;
  logic [NUM_SOCKETS-1:0] win0_q;
  logic [NUM_SOCKETS-1:0] routing_q;
  logic [NUM_SOCKETS-1:0] card_reset_q;
  logic [NUM_SOCKETS-1:0] vga_q;
  logic [NUM_SOCKETS-1:0] isa_q;
  logic [NUM_SOCKETS-1:0] syserr_q;
  logic [NUM_SOCKETS-1:0] parity_q;
  logic                   abort_mode_q;
  logic                   addr_hit;
  logic                   func_ok;
  logic                   wr_lo;
  logic                   wr_hi;
  logic                   ctx_clear;

  assign addr_hit  = (cfg_addr_in == BRIDGING_CONTROL_OFS);
  // A function without a socket behind it answers nothing.
  assign func_ok   = (int'(cfg_func_in) < NUM_SOCKETS);
  assign wr_lo     = cfg_wr_in && addr_hit && func_ok && cfg_byte_en_in[LANE_LO];
  assign wr_hi     = cfg_wr_in && addr_hit && func_ok && cfg_byte_en_in[LANE_HI];
  // Context fields survive a PCI reset while wake events are armed.
  assign ctx_clear = pci_reset_input_in && !pme_enable_in;

  function automatic logic [REG_W-1:0] pack_word(input int s);
    logic [REG_W-1:0] w;
    w = '0;
    w[POS_WRITE_POSTING]    = posting_q[s];
    w[POS_WINDOW1_PREFETCH] = win1_q[s];
    w[POS_WINDOW0_PREFETCH] = win0_q[s];
    w[POS_IRQ_ROUTING]      = routing_q[s];
    w[POS_CARD_RESET]       = card_reset_q[s];
    w[POS_MASTER_ABORT]     = abort_mode_q;
    w[POS_VGA_FORWARD]      = vga_q[s];
    w[POS_ISA_FILTER]       = isa_q[s];
    w[POS_CARD_SYSERR]      = syserr_q[s];
    w[POS_CARD_PARITY]      = parity_q[s];
    return w & BRIDGING_CONTROL_MASK;
  endfunction

  // ==========================================================================
  // Per-socket fields
  // ==========================================================================
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SOCKETS; gs++) begin : g_sock
      logic sel;
      assign sel = (int'(cfg_func_in) == gs);

      // Card reset is kept apart: only the global reset may restore it.
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          card_reset_q[gs] <= BRIDGING_CONTROL_RST[POS_CARD_RESET];
        end else if (wr_lo && sel) begin
          card_reset_q[gs] <= cfg_wdata_in[POS_CARD_RESET];
        end
      end

      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          posting_q[gs] <= BRIDGING_CONTROL_RST[POS_WRITE_POSTING];
          win1_q[gs]    <= BRIDGING_CONTROL_RST[POS_WINDOW1_PREFETCH];
          win0_q[gs]    <= BRIDGING_CONTROL_RST[POS_WINDOW0_PREFETCH];
        end else if (ctx_clear) begin
          posting_q[gs] <= BRIDGING_CONTROL_RST[POS_WRITE_POSTING];
          win1_q[gs]    <= BRIDGING_CONTROL_RST[POS_WINDOW1_PREFETCH];
          win0_q[gs]    <= BRIDGING_CONTROL_RST[POS_WINDOW0_PREFETCH];
        end else if (wr_hi && sel) begin
          posting_q[gs] <= cfg_wdata_in[POS_WRITE_POSTING];
          win1_q[gs]    <= cfg_wdata_in[POS_WINDOW1_PREFETCH];
          win0_q[gs]    <= cfg_wdata_in[POS_WINDOW0_PREFETCH];
        end
      end

      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          routing_q[gs] <= BRIDGING_CONTROL_RST[POS_IRQ_ROUTING];
          vga_q[gs]     <= BRIDGING_CONTROL_RST[POS_VGA_FORWARD];
          isa_q[gs]     <= BRIDGING_CONTROL_RST[POS_ISA_FILTER];
          syserr_q[gs]  <= BRIDGING_CONTROL_RST[POS_CARD_SYSERR];
          parity_q[gs]  <= BRIDGING_CONTROL_RST[POS_CARD_PARITY];
        end else if (ctx_clear) begin
          routing_q[gs] <= BRIDGING_CONTROL_RST[POS_IRQ_ROUTING];
          vga_q[gs]     <= BRIDGING_CONTROL_RST[POS_VGA_FORWARD];
          isa_q[gs]     <= BRIDGING_CONTROL_RST[POS_ISA_FILTER];
          syserr_q[gs]  <= BRIDGING_CONTROL_RST[POS_CARD_SYSERR];
          parity_q[gs]  <= BRIDGING_CONTROL_RST[POS_CARD_PARITY];
        end else if (wr_lo && sel) begin
          routing_q[gs] <= cfg_wdata_in[POS_IRQ_ROUTING];
          vga_q[gs]     <= cfg_wdata_in[POS_VGA_FORWARD];
          isa_q[gs]     <= cfg_wdata_in[POS_ISA_FILTER];
          syserr_q[gs]  <= cfg_wdata_in[POS_CARD_SYSERR];
          parity_q[gs]  <= cfg_wdata_in[POS_CARD_PARITY];
        end
      end

      // Card reset follows the field and the PCI reset together.
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          card_reset_out[gs] <= 1'b1;
        end else begin
          card_reset_out[gs] <= card_reset_q[gs] || pci_reset_input_in;
        end
      end

      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          card_irq_to_pci_out[gs]    <= 1'b0;
          card_irq_to_legacy_out[gs] <= 1'b0;
          card_parity_err_out[gs]    <= 1'b0;
        end else begin
          card_irq_to_pci_out[gs]    <= card_irq_in[gs] && !routing_q[gs];
          card_irq_to_legacy_out[gs] <= card_irq_in[gs] && routing_q[gs];
          card_parity_err_out[gs]    <= card_parity_err_in[gs] && parity_q[gs];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Shared field
  // ==========================================================================
  // Writes through function one are dropped so that the second socket's
  // driver cannot change behaviour of the first socket behind its back.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      abort_mode_q <= BRIDGING_CONTROL_RST[POS_MASTER_ABORT];
    end else if (ctx_clear) begin
      abort_mode_q <= BRIDGING_CONTROL_RST[POS_MASTER_ABORT];
    end else if (wr_lo && !cfg_func_in) begin
      abort_mode_q <= cfg_wdata_in[POS_MASTER_ABORT];
    end
  end

  assign write_posting_enable_out     = posting_q;
  assign window1_prefetchable_out     = win1_q;
  assign window0_prefetchable_out     = win0_q;
  assign irq_routing_select_out       = routing_q;
  assign vga_forward_enable_out       = vga_q;
  assign master_abort_report_mode_out = abort_mode_q;

  // ==========================================================================
  // Read port
  // ==========================================================================
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rdata_out    <= '0;
      cfg_rd_valid_out <= 1'b0;
    end else begin
      cfg_rd_valid_out <= cfg_rd_in;
      if (cfg_rd_in && addr_hit && func_ok) begin
        cfg_rdata_out <= pack_word(int'(cfg_func_in));
      end else if (cfg_rd_in) begin
        cfg_rdata_out <= '0;
      end
    end
  end

  // ==========================================================================
  // I/O filtering and error forwarding
  // ==========================================================================
  logic isa_hit;
  logic io_sock_ok;
  assign io_sock_ok = (int'(io_cycle_socket_in) < NUM_SOCKETS);
  assign isa_hit    = (io_cycle_addr_in[IO_ADDR_W-1:ISA_TOP_BIT] == ISA_UPPER_ZERO) &&
                      (io_cycle_addr_in[ISA_BLOCK_HI:ISA_BLOCK_LO] != ISA_FIRST_QUART);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      io_cycle_blocked_out <= 1'b0;
      io_cycle_decided_out <= 1'b0;
    end else begin
      io_cycle_decided_out <= io_cycle_valid_in;
      io_cycle_blocked_out <= io_cycle_valid_in && io_sock_ok &&
                              isa_q[io_cycle_socket_in] && isa_hit;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pci_target_abort_out <= 1'b0;
      pci_serr_out         <= 1'b0;
    end else begin
      pci_target_abort_out <= abort_mode_q && (|card_master_abort_in);
      pci_serr_out         <= serr_enable_in &&
                              ((abort_mode_q && (|card_master_abort_in)) ||
                               (|(card_syserr_in & syserr_q)));
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_RESERVED_FIELD_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_rd_valid_out |-> (cfg_rdata_out[15:11] == 5'h00))
    else $error("reserved high bits read nonzero");
  AST_BIT4_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_rd_valid_out |-> !cfg_rdata_out[4])
    else $error("reserved bit 4 read nonzero");
  AST_POST_WR: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_hi && !ctx_clear && !cfg_func_in) |=> (posting_q[0] == $past(cfg_wdata_in[10])))
    else $error("posting enable not written");
  AST_CARD_RESET_CONTROL_PASS: assert property (@(posedge clock_in) disable iff (rst_in)
    pci_reset_input_in |=> card_reset_out[0])
    else $error("pci reset not passed to card");
  AST_CARD_RESET_CONTROL_KEEP: assert property (@(posedge clock_in) disable iff (rst_in)
    (pci_reset_input_in && !wr_lo) |=> $stable(card_reset_q))
    else $error("card reset field changed by pci reset");
  AST_CTX_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
    ctx_clear |=> (win1_q[0] && win0_q[0] && !syserr_q[0] && !posting_q[0]))
    else $error("context fields not restored");
  AST_CTX_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
    (pci_reset_input_in && pme_enable_in && !wr_hi) |=> $stable(win1_q))
    else $error("context field lost with events enabled");
  AST_ABORT: assert property (@(posedge clock_in) disable iff (rst_in)
    (!abort_mode_q && !wr_lo) |=> !pci_target_abort_out)
    else $error("master abort reported while mode is zero");
  AST_ISA: assert property (@(posedge clock_in) disable iff (rst_in)
    (io_cycle_valid_in && !io_cycle_socket_in && isa_q[0] &&
     io_cycle_addr_in[31:16] == 16'h0000 && io_cycle_addr_in[9:8] == 2'h0)
    |=> (io_cycle_decided_out && !io_cycle_blocked_out))
    else $error("first quarter of ISA block blocked");
  AST_PERR: assert property (@(posedge clock_in) disable iff (rst_in)
    (card_parity_err_in[0] && !parity_q[0]) |=> !card_parity_err_out[0])
    else $error("parity error reported while disabled");
  AST_SERR: assert property (@(posedge clock_in) disable iff (rst_in)
    (serr_enable_in && card_syserr_in[0] && syserr_q[0]) |=> pci_serr_out)
    else $error("card system error not forwarded");

  COV_WRITE_READ: cover property (@(posedge clock_in) disable iff (rst_in)
    wr_lo ##1 cfg_rd_in && addr_hit);
  COV_CARD_RELEASE: cover property (@(posedge clock_in) disable iff (rst_in)
    card_reset_out[0] ##1 !card_reset_out[0]);
  COV_ISA_BLOCK: cover property (@(posedge clock_in) disable iff (rst_in)
    io_cycle_blocked_out);
endmodule

// file: bench/tb_cbbc.sv
// Purpose: Self-checking bench for the bridging control register bank.
// Assumes: Two sockets; inputs change by non-blocking assignment at the rising edge.
// Notes:   Expected words follow the register layout, never the design outputs.
`timescale 1ns/1ps
`define CHK(got, exp) check_val(16'(got), 16'(exp))
module tb;
  import cbbc_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                 clock_in, rst_in, pci_reset_input_in, pme_enable_in;
  logic                 cfg_wr_in, cfg_rd_in, cfg_func_in, cfg_rd_valid_out;
  logic [ADDR_W-1:0]    cfg_addr_in;
  logic [1:0]           cfg_byte_en_in;
  logic [REG_W-1:0]     cfg_wdata_in, cfg_rdata_out;
  logic [1:0]           wpe, w1, w0, irs, vga, card_reset_control, irq_in, irq_pci, irq_leg;
  logic [1:0]           mabt_in, syserr_in, par_in, par_out;
  logic                 mabt_mode, io_valid, io_sock, io_blocked, io_decided;
  logic                 serr_en, tabt, serr;
  logic [IO_ADDR_W-1:0] io_addr;
  int                   mismatches = 0;
  int                   n_tests    = 0;

  cbbc_bridging_control #(.NUM_SOCKETS(2)) dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .pci_reset_input_in(pci_reset_input_in),
    .pme_enable_in(pme_enable_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_func_in(cfg_func_in), .cfg_addr_in(cfg_addr_in), .cfg_byte_en_in(cfg_byte_en_in),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_rd_valid_out(cfg_rd_valid_out), .write_posting_enable_out(wpe),
    .window1_prefetchable_out(w1), .window0_prefetchable_out(w0),
    .irq_routing_select_out(irs), .vga_forward_enable_out(vga), .card_reset_out(card_reset_control),
    .master_abort_report_mode_out(mabt_mode), .card_irq_in(irq_in),
    .card_irq_to_pci_out(irq_pci), .card_irq_to_legacy_out(irq_leg),
    .io_cycle_valid_in(io_valid), .io_cycle_socket_in(io_sock), .io_cycle_addr_in(io_addr),
    .io_cycle_blocked_out(io_blocked), .io_cycle_decided_out(io_decided),
    .card_master_abort_in(mabt_in), .card_syserr_in(syserr_in),
    .card_parity_err_in(par_in), .serr_enable_in(serr_en),
    .pci_target_abort_out(tabt), .pci_serr_out(serr), .card_parity_err_out(par_out));

  // ==========================================================================
  // Clock, checks and access tasks
  // ==========================================================================
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic wr(input logic f, input logic [7:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(posedge clock_in);
    cfg_wr_in      <= 1'b1;
    cfg_func_in    <= f;
    cfg_addr_in    <= a;
    cfg_byte_en_in <= be;
    cfg_wdata_in   <= d;
    @(posedge clock_in);
    cfg_wr_in      <= 1'b0;
  endtask

  // Reads wait a bounded time for the valid pulse, then compare the word.
  task automatic rdc(input logic f, input logic [7:0] a, input logic [15:0] e);
    int i;
    @(posedge clock_in);
    cfg_rd_in   <= 1'b1;
    cfg_func_in <= f;
    cfg_addr_in <= a;
    @(posedge clock_in);
    cfg_rd_in   <= 1'b0;
    #1;
    i = 0;
    while (cfg_rd_valid_out !== 1'b1 && i < 4) begin
      @(posedge clock_in);
      #1;
      i++;
    end
    if (cfg_rd_valid_out !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: valid got %h expected %h", $time, cfg_rd_valid_out, 1'b1);
      final_report();
    end
    `CHK(cfg_rdata_out, e);
  endtask

  task automatic io(input logic s, input logic [31:0] a, input logic e);
    @(posedge clock_in);
    io_valid <= 1'b1;
    io_sock  <= s;
    io_addr  <= a;
    @(posedge clock_in);
    io_valid <= 1'b0;
    #1;
    `CHK(io_decided, 1'b1);
    `CHK(io_blocked, e);
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    $display("Error at %0t: run got %h expected %h", $time, 1'b0, 1'b1);
    final_report();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {rst_in, pci_reset_input_in, pme_enable_in, cfg_wr_in, cfg_rd_in} = 5'h10;
    {cfg_func_in, cfg_addr_in, cfg_byte_en_in, cfg_wdata_in} = '0;
    {irq_in, mabt_in, syserr_in, par_in, io_valid, io_sock, io_addr, serr_en} = '0;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    rdc(0, BRIDGING_CONTROL_OFS, 16'h0340);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h0340);
    `CHK({card_reset_control, w1, w0, irs, wpe}, 10'h3F0);
    $display("Test reset_values done");
    // Socket 1 cannot set the shared abort mode; bits 15:11 and 4 stay zero.
    wr(1, BRIDGING_CONTROL_OFS, 2'h3, 16'hFFFF);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h07CF);
    rdc(0, BRIDGING_CONTROL_OFS, 16'h0340);
    `CHK({mabt_mode, wpe}, 3'h2);
    wr(0, BRIDGING_CONTROL_OFS, 2'h3, 16'hFFBF);
    rdc(0, BRIDGING_CONTROL_OFS, 16'h07AF);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h07EF);
    cyc(2);
    `CHK({mabt_mode, card_reset_control}, 3'h6);
    $display("Test mask_and_sharing done");
    wr(0, BRIDGING_CONTROL_OFS, 2'h1, 16'h0000);
    rdc(0, BRIDGING_CONTROL_OFS, 16'h0700);
    wr(0, 8'h3C, 2'h3, 16'h0000);
    rdc(0, BRIDGING_CONTROL_OFS, 16'h0700);
    rdc(0, 8'h3C, 16'h0000);
    wr(0, BRIDGING_CONTROL_OFS, 2'h1, 16'h00AF);
    wr(1, BRIDGING_CONTROL_OFS, 2'h1, 16'h004A);
    wr(1, BRIDGING_CONTROL_OFS, 2'h2, 16'h0100);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h016A);
    `CHK({wpe, w1, w0, irs, vga}, 10'h177);
    $display("Test byte_lanes done");
    @(posedge clock_in);
    irq_in <= 2'h3;
    cyc(2);
    `CHK({irq_pci, irq_leg}, 4'h9);
    irq_in <= 2'h0;
    io(0, 32'h0000_0100, 1'b1);
    io(0, 32'h0000_00FF, 1'b0);
    io(0, 32'h0000_FFFF, 1'b1);
    io(0, 32'h0001_0100, 1'b0);
    io(1, 32'h0000_0100, 1'b0);
    $display("Test routing_and_filter done");
    @(posedge clock_in);
    serr_en   <= 1'b1;
    syserr_in <= 2'h2;
    cyc(2);
    `CHK(serr, 1'b1);
    serr_en <= 1'b0;
    cyc(2);
    `CHK(serr, 1'b0);
    {serr_en, syserr_in, mabt_in, par_in} <= 7'h47;
    cyc(2);
    `CHK({tabt, serr, par_out}, 4'hD);
    {serr_en, mabt_in, par_in} <= '0;
    $display("Test error_forwarding done");
    @(posedge clock_in);
    pci_reset_input_in <= 1'b1;
    cyc(2);
    `CHK(card_reset_control, 2'h3);
    pci_reset_input_in <= 1'b0;
    cyc(2);
    `CHK(card_reset_control, 2'h2);
    rdc(0, BRIDGING_CONTROL_OFS, 16'h0300);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h0340);
    mabt_in <= 2'h1;
    cyc(2);
    `CHK({mabt_mode, tabt}, 2'h0);
    mabt_in <= 2'h0;
    wr(0, BRIDGING_CONTROL_OFS, 2'h3, 16'h07AF);
    pme_enable_in      <= 1'b1;
    pci_reset_input_in <= 1'b1;
    cyc(3);
    pci_reset_input_in <= 1'b0;
    rdc(0, BRIDGING_CONTROL_OFS, 16'h07AF);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h0360);
    $display("Test pci_reset done");
    @(posedge clock_in);
    rst_in <= 1'b1;
    cyc(3);
    `CHK(card_reset_control, 2'h3);
    rst_in <= 1'b0;
    rdc(0, BRIDGING_CONTROL_OFS, 16'h0340);
    rdc(1, BRIDGING_CONTROL_OFS, 16'h0340);
    $display("Test global_reset done");
    final_report();
  end
endmodule
